// ===== design/ivd_defines.svh
// Constants for the interrupt vector and transfer-request map
`ifndef IVD_DEFINES_SVH
`define IVD_DEFINES_SVH
`define IVD_NSRC        27
`define IVD_NLINE       48
`define IVD_VEC_BASE    8'h10
`define IVD_VEC_SW_MIN  8'h42
`define IVD_OFS_LAST    32'h0000_03FC
`define IVD_TBR_RST     32'h000F_FC00
`define IVD_SRCEN_RST   27'h7FF_FFFF
`define IVD_DMAEN_RST   1'h1
`define IVD_RN_MASK     48'h3FFF_FFC3_FFFF
`define IVD_REG_SRCEN   12'h000
`define IVD_REG_DMAEN   12'h004
`define IVD_REG_TBR     12'h008
`define IVD_REG_STAT    12'h00C
`define IVD_REG_SWINT   12'h010
`define IVD_S_SER2TX    0
`define IVD_S_RAMDIAG   1
`define IVD_S_RAMINIT   2
`define IVD_S_RAMERR    3
`define IVD_S_UDC0      4
`define IVD_S_UDC3      7
`define IVD_S_FRT0ZERO  8
`define IVD_S_FRT0CLR   9
`define IVD_S_SER7TX    10
`define IVD_S_WGUNDER   11
`define IVD_S_WGRELOAD  12
`define IVD_S_ESTOP0    13
`define IVD_S_ICU9      14
`define IVD_S_ICU4      15
`define IVD_S_ICU10     16
`define IVD_S_SER11TX   17
`define IVD_S_ADCHI     18
`define IVD_S_BUSCTL    19
`define IVD_S_BUSTMR    20
`define IVD_S_CLKCAL    21
`define IVD_S_FRT32     22
`define IVD_S_I2CSTAT   23
`define IVD_S_PPGHI     24
`define IVD_S_RLTHI     25
`define IVD_S_LVD       26
`endif

// ===== design/ivd_fetch_calc.sv
// Registered handler-address calculation for an accepted vector
`timescale 1ns/10ps
`default_nettype none
`include "ivd_defines.svh"
module ivd_fetch_calc (
    // Clock and control
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              clkEn,
    // Accepted vector and table base
    input  wire ivd_pkg::ivd_ack_t ack,
    input  wire logic [31:0]       tableBase,
    // Handler address
    output var  ivd_pkg::ivd_fetch_t fetch
);
    import ivd_pkg::*;
    ivd_fetch_t fetch_q;
    ivd_fetch_t fetch_d;

    always_comb begin
        fetch_d       = fetch_q;
        fetch_d.valid = ack.valid;
        if (ack.valid) begin
            // Table grows downward from the last slot
            fetch_d.addr = tableBase + `IVD_OFS_LAST - {22'h0, ack.vec, 2'h0};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fetch_q <= '0;
        end else if (clkEn) begin
            fetch_q <= fetch_d;
        end
    end

    assign fetch = fetch_q;
endmodule
`default_nettype wire

// ===== design/ivd_map.sv
// Peripheral interrupt to vector and transfer-request mapping with APB registers
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "ivd_defines.svh"
module ivd_map #(
    parameter int NSRC  = `IVD_NSRC,
    parameter int NLINE = `IVD_NLINE
) (
    // Clock, reset and enable
    input  wire logic                ref_clk,
    input  wire logic                srst,
    input  wire logic                clkEn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output var  logic [31:0]         prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    // Peripheral source flags
    input  wire logic [NSRC-1:0]     srcFlag,
    input  wire logic [31:0]         adcHiFlag,
    // CPU exception logic
    output var  logic [NLINE-1:0]    irqLine,
    output var  ivd_pkg::ivd_sw_t    swIrq,
    input  wire ivd_pkg::ivd_ack_t   cpuAck,
    output var  ivd_pkg::ivd_fetch_t fetch,
    // Transfer controller, indexed by resource number
    output var  logic [NLINE-1:0]    dmaReq
);
    import ivd_pkg::*;

    // Vector of each source
    localparam logic [7:0] SRC_VEC [NSRC] = '{
        8'h19,
        8'h23, 8'h23, 8'h23,
        8'h24, 8'h24, 8'h24, 8'h24,
        8'h27, 8'h27, 8'h27,
        8'h37, 8'h37, 8'h37, 8'h37,
        8'h38, 8'h38, 8'h38,
        8'h39,
        8'h1F, 8'h21,
        8'h2F,
        8'h33,
        8'h2F,
        8'h2A,
        8'h13,
        8'h11
    };

    // Sources allowed to forward a transfer request
    localparam logic [NSRC-1:0] DMA_OK = {
        1'h0, 1'h0, 1'h0,
        1'h0, 1'h0, 1'h0, 1'h0, 1'h0,
        1'h1, 3'h7, 4'hF, 3'h7,
        4'h0, 3'h0, 1'h1
    };

    // Lines that own a resource number; a literal cannot be bit-selected
    localparam logic [NLINE-1:0] RN_MASK = `IVD_RN_MASK;

    function automatic logic [NSRC-1:0] selMask(input int line);
        logic [NSRC-1:0] m;
        m = '0;
        for (int i = 0; i < NSRC; i++) begin
            m[i] = (SRC_VEC[i] == 8'(line + 16));
        end
        return m;
    endfunction

    // Register state
    logic [NSRC-1:0]  srcEn_q;
    logic [NSRC-1:0]  srcEn_d;
    logic             dmaEn_q;
    logic             dmaEn_d;
    logic [31:0]      tbr_q;
    logic [31:0]      tbr_d;
    logic [31:0]      rdata_q;
    logic [31:0]      rdata_d;
    logic             err_q;
    logic             err_d;
    // Request state
    logic [NLINE-1:0] irq_q;
    logic [NLINE-1:0] irq_d;
    logic [NLINE-1:0] dma_q;
    logic [NLINE-1:0] dma_d;
    ivd_sw_state_t    swSt_q;
    ivd_sw_state_t    swSt_d;
    logic [7:0]       swVec_q;
    logic [7:0]       swVec_d;

    logic [NSRC-1:0]  act;
    logic [NSRC-1:0]  live;
    logic [NLINE-1:0] hit;
    logic [NLINE-1:0] dmaHit;
    logic             setup;
    logic             wrEn;
    logic             mapped;
    logic             swWr;
    logic             swOk;

    // Converter channels fold into one source
    always_comb begin
        act = srcFlag;
        act[`IVD_S_ADCHI] = srcFlag[`IVD_S_ADCHI] | (|adcHiFlag);
    end

    assign live = act & srcEn_q;

    // Only vectors 16 to 63 exist as lines; 64 and up have none
    for (genvar v = 0; v < NLINE; v++) begin : g_line
        assign hit[v]    = |(live & selMask(v));
        assign dmaHit[v] = |(live & DMA_OK & selMask(v)) & RN_MASK[v];
    end

    always_comb begin
        irq_d = hit;
        dma_d = dmaEn_q ? dmaHit : '0;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_q <= '0;
            dma_q <= '0;
        end else if (clkEn) begin
            irq_q <= irq_d;
            dma_q <= dma_d;
        end
    end

    // APB decode; read data captured in setup so no wait state
    assign setup  = psel & ~penable;
    assign wrEn   = psel & penable & pwrite;
    assign mapped = (paddr == `IVD_REG_SRCEN) || (paddr == `IVD_REG_DMAEN) ||
                    (paddr == `IVD_REG_TBR) || (paddr == `IVD_REG_STAT) ||
                    (paddr == `IVD_REG_SWINT);
    assign swWr   = wrEn && (paddr == `IVD_REG_SWINT);
    assign swOk   = pwdata[7:0] >= `IVD_VEC_SW_MIN;

    always_comb begin
        srcEn_d = srcEn_q;
        dmaEn_d = dmaEn_q;
        tbr_d   = tbr_q;
        rdata_d = rdata_q;
        err_d   = err_q;
        if (setup) begin
            err_d   = ~mapped;
            rdata_d = '0;
            unique case (paddr)
                `IVD_REG_SRCEN: rdata_d[NSRC-1:0] = srcEn_q;
                `IVD_REG_DMAEN: rdata_d[0] = dmaEn_q;
                `IVD_REG_TBR:   rdata_d = tbr_q;
                `IVD_REG_STAT:  rdata_d[NSRC-1:0] = act;
                `IVD_REG_SWINT: rdata_d[7:0] = swVec_q;
                default:        rdata_d = '0;
            endcase
        end
        if (wrEn) begin
            unique case (paddr)
                `IVD_REG_SRCEN: srcEn_d = pwdata[NSRC-1:0];
                `IVD_REG_DMAEN: dmaEn_d = pwdata[0];
                `IVD_REG_TBR:   tbr_d = {pwdata[31:2], 2'h0};
                default:        tbr_d = tbr_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            srcEn_q <= `IVD_SRCEN_RST;
            dmaEn_q <= `IVD_DMAEN_RST;
            tbr_q   <= `IVD_TBR_RST;
            rdata_q <= '0;
            err_q   <= 1'h0;
        end else if (clkEn) begin
            srcEn_q <= srcEn_d;
            dmaEn_q <= dmaEn_d;
            tbr_q   <= tbr_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    // Software interrupt; a new write beats a same-cycle acknowledge
    always_comb begin
        swSt_d  = swSt_q;
        swVec_d = swVec_q;
        unique case (swSt_q)
            SW_IDLE: begin
                if (swWr && swOk) begin
                    swSt_d  = SW_PEND;
                    swVec_d = pwdata[7:0];
                end
            end
            SW_PEND: begin
                if (swWr && swOk) begin
                    swVec_d = pwdata[7:0];
                end else if (cpuAck.valid && cpuAck.vec == swVec_q) begin
                    swSt_d = SW_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            swSt_q  <= SW_IDLE;
            swVec_q <= '0;
        end else if (clkEn) begin
            swSt_q  <= swSt_d;
            swVec_q <= swVec_d;
        end
    end

    ivd_fetch_calc u_fetch (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .clkEn     (clkEn),
        .ack       (cpuAck),
        .tableBase (tbr_q),
        .fetch     (fetch)
    );

    assign prdata      = rdata_q;
    assign pready      = psel & penable;
    assign pslverr     = psel & penable & err_q;
    assign irqLine     = irq_q;
    assign dmaReq      = dma_q;
    assign swIrq.valid = (swSt_q == SW_PEND);
    assign swIrq.vec   = swVec_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    a_ser2_line: assert property (clkEn && live[`IVD_S_SER2TX] && dmaEn_q
        |=> irqLine[9] && dmaReq[9])
        else $error("serial 2 transmit not mapped to vector 25");
    a_ram_nodma: assert property (clkEn && |live[`IVD_S_RAMERR:`IVD_S_RAMDIAG]
        |=> irqLine[19] && !dmaReq[19])
        else $error("RAM events not on vector 35 or requested DMA");
    a_udc_line: assert property (clkEn && |live[`IVD_S_UDC3:`IVD_S_UDC0]
        |=> irqLine[20])
        else $error("up/down counter not on vector 36");
    a_frt0_dma: assert property (clkEn && dmaEn_q && live[`IVD_S_FRT0CLR]
        |=> irqLine[23] && dmaReq[23])
        else $error("timer 0 clear not on resource 23");
    a_wg_dma: assert property (clkEn && dmaEn_q && live[`IVD_S_ESTOP0]
        |=> irqLine[39] && dmaReq[39])
        else $error("emergency stop not on resource 39");
    a_icu_dma: assert property (clkEn && dmaEn_q && live[`IVD_S_ICU10]
        |=> irqLine[40] && dmaReq[40])
        else $error("capture 10 not on resource 40");
    a_adc_dma: assert property (clkEn && dmaEn_q && srcEn_q[`IVD_S_ADCHI]
        && (|adcHiFlag) |=> irqLine[41] && dmaReq[41])
        else $error("converter high channels not on resource 41");
    a_sw_range: assert property (swIrq.valid |-> swIrq.vec >= `IVD_VEC_SW_MIN)
        else $error("software vector below 66 pending");
    a_norn_dma: assert property ((dmaReq & ~`IVD_RN_MASK) == '0)
        else $error("DMA request on vector without resource");
    a_excl_dma: assert property (clkEn && !(|(live & DMA_OK))
        |=> dmaReq == '0)
        else $error("excluded source produced DMA request");
    a_line_drop: assert property (clkEn && live == '0 |=> irqLine == '0)
        else $error("interrupt line held with no source set");
    a_fetch_addr: assert property (clkEn && cpuAck.valid
        |=> fetch.valid && fetch.addr == $past(tbr_q) + `IVD_OFS_LAST
        - {22'h0, $past(cpuAck.vec), 2'h0})
        else $error("handler address wrong");
    a_sw_refuse: assert property (clkEn && !swIrq.valid && swWr && !swOk
        |=> !swIrq.valid)
        else $error("reserved or low software vector accepted");
    a_sw_hold: assert property (clkEn && swIrq.valid && !swWr && !cpuAck.valid
        |=> swIrq.valid && swIrq.vec == $past(swIrq.vec))
        else $error("pending software vector lost");
    a_sw_clear: assert property (clkEn && swIrq.valid && !swWr && cpuAck.valid
        && cpuAck.vec == swIrq.vec |=> !swIrq.valid)
        else $error("software vector not cleared by acknowledge");
    a_freeze_hold: assert property (!clkEn |=> irqLine == $past(irqLine)
        && dmaReq == $past(dmaReq) && fetch == $past(fetch))
        else $error("state moved while clock enable low");

    c_dma_frt0: cover property (dmaReq[23] && irqLine[23]);
    c_sw_ack: cover property (swIrq.valid ##1 !swIrq.valid);
    c_shared: cover property (live[`IVD_S_WGUNDER] && live[`IVD_S_ICU9]);
    c_fetch: cover property (fetch.valid);
endmodule
`default_nettype wire

// ===== design/ivd_pkg.sv
// Types for the interrupt vector and transfer-request map
package ivd_pkg;
    typedef struct packed {
        logic       valid;
        logic [7:0] vec;
    } ivd_ack_t;
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } ivd_fetch_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] vec;
    } ivd_sw_t;
    typedef enum logic {
        SW_IDLE,
        SW_PEND
    } ivd_sw_state_t;
endpackage

// ===== sim/ivd_cpu_model.sv
// CPU exception logic model: takes software vectors, collects handler addresses
`timescale 1ns/10ps
`default_nettype none
module ivd_cpu_model (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                srst,
    // Requests from the map, and the slow-mode select from the bench
    input  wire ivd_pkg::ivd_sw_t    swIrq,
    input  wire ivd_pkg::ivd_fetch_t fetch,
    input  wire logic                slow,
    // Acknowledge and observation
    output var  ivd_pkg::ivd_ack_t   cpuAck,
    output var  logic [31:0]         lastAddr,
    output var  int                  fetchCount
);
    import ivd_pkg::*;
    int n;
    // One process owns every output, so each has a single driver
    // Slow mode leaves the vector pending for a few cycles
    initial begin
        cpuAck = '0;
        lastAddr = '0;
        fetchCount = 0;
        forever begin
            @(posedge ref_clk);
            if (!srst && swIrq.valid === 1'b1) begin
                repeat (slow ? 3 : 0) @(posedge ref_clk);
                cpuAck <= '{valid: 1'b1, vec: swIrq.vec};
                @(posedge ref_clk);
                cpuAck <= '0;
                n = 0;
                do begin
                    @(posedge ref_clk);
                    n++;
                end while (fetch.valid !== 1'b1 && n < 4);
                lastAddr <= fetch.addr;
                fetchCount <= fetchCount + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/ivd_map_bench.sv
// Self-checking bench for the vector and transfer-request map
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("wrong value at %0t: %s", $time, msg); \
        end \
    end
module ivd_map_bench;
    import ivd_pkg::*;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        clkEn = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [26:0] srcFlag = '0;
    logic [31:0] adcHiFlag = '0;
    logic [47:0] irqLine;
    logic [47:0] dmaReq;
    ivd_sw_t     swIrq;
    ivd_ack_t    cpuAck;
    ivd_fetch_t  fetch;
    logic        slow = 1'b0;
    logic [31:0] lastAddr;
    int          fetchCount;
    int          num_errors = 0;
    int          num_checks = 0;
    logic [31:0] rd;
    logic        er;
    // Vector of each source; only some may request a transfer
    int          vecOf [27] = '{25, 35, 35, 35, 36, 36, 36, 36, 39, 39, 39, 55, 55, 55,
                                55, 56, 56, 56, 57, 31, 33, 47, 51, 47, 42, 19, 17};
    logic [26:0] dmaOk = 27'h007_FF01;

    ivd_map i_ivd_map (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .srcFlag(srcFlag),
        .adcHiFlag(adcHiFlag), .irqLine(irqLine), .swIrq(swIrq), .cpuAck(cpuAck),
        .fetch(fetch), .dmaReq(dmaReq));
    ivd_cpu_model i_ivd_cpu_model (.ref_clk(ref_clk), .srst(srst), .swIrq(swIrq),
        .fetch(fetch), .slow(slow), .cpuAck(cpuAck), .lastAddr(lastAddr),
        .fetchCount(fetchCount));

    always #20 ref_clk = ~ref_clk;

    task conclude;
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One APB transfer, then an idle cycle so strobes are never set twice at one edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        `CHK(pready, 1'b1, "no ready")
        if (pready !== 1'b1)
            conclude();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task swv(input logic [7:0] v, input logic [31:0] exp);
        int c;
        int n;
        c = fetchCount;
        apb(1'b1, 12'h010, {24'h0, v});
        @(posedge ref_clk);
        if (slow) begin
            `CHK(swIrq, {1'b1, v}, "soft vector")
            // Read back while still pending; acknowledge comes later
            apb(1'b0, 12'h010, '0);
            `CHK(rd, {24'h0, v}, "pending vector")
        end
        n = 0;
        while (fetchCount == c && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        if (fetchCount == c) begin
            num_errors++;
            conclude();
        end
        `CHK(lastAddr, exp, "handler address")
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        apb(1'b0, 12'h000, '0);
        `CHK(rd, 32'h07FF_FFFF, "enable reset")
        apb(1'b0, 12'h004, '0);
        `CHK(rd, 32'h0000_0001, "dma enable reset")
        apb(1'b0, 12'h008, '0);
        `CHK(rd, 32'h000F_FC00, "base reset")
        apb(1'b0, 12'h020, '0);
        `CHK({er, rd}, 33'h0_0000_0000 | 33'h1_0000_0000, "unmapped")
        for (int k = 0; k < 27; k++) begin
            srcFlag <= 27'h1 << k;
            repeat (2) @(posedge ref_clk);
            `CHK(irqLine, 48'h1 << (vecOf[k] - 16), "vector")
            `CHK(dmaReq, dmaOk[k] ? 48'h1 << (vecOf[k] - 16) : 48'h0, "dma")
            srcFlag <= '0;
            repeat (2) @(posedge ref_clk);
            `CHK({irqLine, dmaReq}, 96'h0, "drop")
        end
        adcHiFlag <= 32'h8000_0000;
        repeat (2) @(posedge ref_clk);
        `CHK({irqLine, dmaReq}, {48'h1 << 41, 48'h1 << 41}, "converter")
        adcHiFlag <= '0;
        // Shared line must hold while the second source stays set
        srcFlag <= 27'h000_0500;
        repeat (2) @(posedge ref_clk);
        srcFlag <= 27'h000_0400;
        repeat (2) @(posedge ref_clk);
        `CHK(irqLine, 48'h1 << 23, "shared hold")
        `CHK(dmaReq, 48'h1 << 23, "shared dma")
        // Enable low must freeze the lines although the source drops
        clkEn <= 1'b0;
        srcFlag <= '0;
        repeat (3) @(posedge ref_clk);
        `CHK({irqLine, dmaReq}, {48'h1 << 23, 48'h1 << 23}, "frozen")
        clkEn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK({irqLine, dmaReq}, 96'h0, "thawed")
        srcFlag <= 27'h000_0001;
        apb(1'b1, 12'h000, 32'h07FF_FFFE);
        apb(1'b0, 12'h00C, '0);
        `CHK(rd, 32'h0000_0001, "raw status")
        `CHK(irqLine, 48'h0, "masked")
        apb(1'b1, 12'h000, 32'h07FF_FFFF);
        apb(1'b1, 12'h004, 32'h0);
        @(posedge ref_clk);
        `CHK({irqLine, dmaReq}, {48'h1 << 9, 48'h0}, "dma off")
        apb(1'b1, 12'h004, 32'h1);
        srcFlag <= '0;
        slow <= 1'b1;
        apb(1'b1, 12'h010, 32'h41);
        repeat (2) @(posedge ref_clk);
        `CHK(swIrq.valid, 1'b0, "reserved vector")
        swv(8'h42, 32'h000F_FEF4);
        slow <= 1'b0;
        swv(8'hFF, 32'h000F_FC00);
        apb(1'b1, 12'h008, 32'h0002_0000);
        swv(8'h64, 32'h0002_0000 + 32'h3FC - 32'd400);
        conclude();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
